// ===== sra_pkg.sv
// How it works
// - Number bit 5 clear: invalid gives illegal
// - Bit 5 set, supervisor: invalid gives illegal
// - Bit 5 set, user: invalid gives privilege
// - Wrong-direction access counts as invalid reference
// - Every special register is 32 bits
// - Bit 0 is the most significant bit
// - Vector status register open to user state
// - Machine-check syndrome privileged, read and clear
// - Five context-synchronizing operations recognised
// - Syndrome write clears bits set in operand
package sra_pkg;
  localparam int SRA_NUM_REGS = 47;
  localparam int SRA_IDX_W = 6;
  localparam int SRA_NUM_W = 10;
  localparam int SRA_PRIV_BIT = 5;
  localparam int SRA_WORD_W = 32;

  typedef logic [0:SRA_WORD_W-1] sra_word_type;
  typedef logic [0:SRA_NUM_W-1] sra_num_type;
  typedef logic [SRA_IDX_W-1:0] sra_idx_type;

  typedef enum logic [2:0] {
    SRA_OP_NONE = 3'h0,
    SRA_OP_SYSCALL = 3'h1,
    SRA_OP_ISYNC = 3'h2,
    SRA_OP_RFI = 3'h3,
    SRA_OP_RFCI = 3'h4,
    SRA_OP_RFDI = 3'h5,
    SRA_OP_MSYNC = 3'h6
  } sra_op_type;

  typedef struct packed {
    logic valid;
    logic write;
    sra_num_type number;
    sra_word_type data;
  } sra_req_type;

  typedef struct packed {
    logic hit;
    sra_idx_type idx;
    logic readOnly;
    logic privileged;
    logic clearOnWrite;
    logic needSyncAfter;
  } sra_decode_type;

  // Implemented register numbers, index order
  localparam logic [SRA_NUM_W-1:0] SRA_NUMBER [0:SRA_NUM_REGS-1] = '{
    10'h008, 10'h009, 10'h016, 10'h030, 10'h036, 10'h03A, 10'h03B, 10'h03D,
    10'h03E, 10'h03F, 10'h11E, 10'h11F, 10'h130, 10'h134, 10'h135, 10'h136,
    10'h200, 10'h203, 10'h204, 10'h231, 10'h232, 10'h233, 10'h234, 10'h239,
    10'h23A, 10'h23B, 10'h23C, 10'h23D, 10'h23E, 10'h23F, 10'h240, 10'h25B,
    10'h270, 10'h271, 10'h272, 10'h273, 10'h274, 10'h276, 10'h3BF, 10'h3CF,
    10'h3F0, 10'h3F1, 10'h3F2, 10'h3F3, 10'h3F4, 10'h3F5, 10'h3F7};

  // Per-index attribute bits, bit i belongs to index i
  localparam logic [SRA_NUM_REGS-1:0] SRA_USER_OK = 47'h0080_4007_0003;
  localparam logic [SRA_NUM_REGS-1:0] SRA_READ_ONLY = 47'h4000_0086_0800;
  localparam logic [SRA_NUM_REGS-1:0] SRA_CLEAR_ON_WRITE = 47'h0000_0400_1000;
  localparam logic [SRA_NUM_REGS-1:0] SRA_SYNC_AFTER = 47'h3E7F_8079_E008;

  localparam sra_idx_type SRA_IDX_CORE_VERSION = 6'h0B;
  localparam sra_idx_type SRA_IDX_DEBUG_STATUS = 6'h0C;
  localparam sra_idx_type SRA_IDX_VECTOR_STATUS = 6'h10;
  localparam sra_idx_type SRA_IDX_MC_SYNDROME = 6'h1A;
  localparam sra_num_type SRA_NUM_VECTOR_STATUS = 10'h200;
  localparam sra_num_type SRA_NUM_MC_SYNDROME = 10'h23C;

  localparam sra_word_type SRA_ZERO_WORD = 32'h0000_0000;
endpackage : sra_pkg

// ===== sra_decode.sv
`timescale 1ns/100ps
`default_nettype none
module sra_decode (
  // Lookup
  input wire sra_pkg::sra_num_type number,
  output sra_pkg::sra_decode_type info
);
  logic [sra_pkg::SRA_NUM_REGS-1:0] match;

  genvar g;
  generate
    for (g = 0; g < sra_pkg::SRA_NUM_REGS; g++) begin : g_match
      assign match[g] = (number == sra_pkg::SRA_NUMBER[g]);
    end
  endgenerate

  // Unlisted numbers leave hit low
  always_comb begin
    info = '0;
    for (int i = 0; i < sra_pkg::SRA_NUM_REGS; i++) begin
      if (match[i]) begin
        info.hit = 1'b1;
        info.idx = sra_pkg::sra_idx_type'(i);
        info.readOnly = sra_pkg::SRA_READ_ONLY[i];
        info.privileged = !sra_pkg::SRA_USER_OK[i];
        info.clearOnWrite = sra_pkg::SRA_CLEAR_ON_WRITE[i];
        info.needSyncAfter = sra_pkg::SRA_SYNC_AFTER[i];
      end
    end
  end
endmodule : sra_decode
`default_nettype wire

// ===== sra_sync_track.sv
`timescale 1ns/100ps
`default_nettype none
module sra_sync_track (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Instruction stream
  input wire logic opValid,
  input wire sra_pkg::sra_op_type opKind,
  input wire logic alterDone,
  // Status
  output logic contextSync,
  output logic syncPending
);
  logic isCsi;

  always_comb begin
    case (opKind)
      sra_pkg::SRA_OP_SYSCALL, sra_pkg::SRA_OP_ISYNC, sra_pkg::SRA_OP_RFI,
      sra_pkg::SRA_OP_RFCI, sra_pkg::SRA_OP_RFDI: isCsi = opValid;
      default: isCsi = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      contextSync <= 1'b0;
    end else begin
      contextSync <= isCsi;
    end
  end

  // A new alteration in the same cycle as a sync keeps the flag
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      syncPending <= 1'b0;
    end else if (alterDone) begin
      syncPending <= 1'b1;
    end else if (isCsi) begin
      syncPending <= 1'b0;
    end
  end

  a_sync_clears: assert property (@(posedge clk) disable iff (!nrst)
    (isCsi && !alterDone) |=> !syncPending)
    else $error("pending sync not cleared by context sync");
endmodule : sra_sync_track
`default_nettype wire

// ===== sra_access_check.sv
`timescale 1ns/100ps
`default_nettype none
module sra_access_check #(
  // Arbitrary value, not a real part code
  parameter sra_pkg::sra_word_type CORE_VERSION = 32'h0001_0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Move request from the pipeline
  input wire sra_pkg::sra_req_type req,
  input wire logic problemStateBit,
  // Instruction stream classification
  input wire logic opValid,
  input wire sra_pkg::sra_op_type opKind,
  // Hardware event sources for read and clear registers
  input wire sra_pkg::sra_word_type mcSyndromeSet,
  input wire sra_pkg::sra_word_type debugStatusSet,
  // Answer
  output logic ackValid,
  output logic gprWriteEn,
  output sra_pkg::sra_word_type readData,
  output logic illegalExc,
  output logic privExc,
  // Synchronization status and vector status control copy
  output logic contextSync,
  output logic syncPending,
  output sra_pkg::sra_word_type vectorStatusControl
);
  sra_pkg::sra_decode_type info;
  sra_pkg::sra_word_type regFile [0:sra_pkg::SRA_NUM_REGS-1];
  logic wrongDir;
  logic invalidRef;
  logic privViolation;
  logic next_illegal;
  logic next_priv;
  logic accessOk;
  logic doWrite;
  logic doRead;
  logic alterDone;

  sra_decode u_decode (
    .number(req.number),
    .info(info)
  );

  sra_sync_track u_sync (
    .clk(clk),
    .nrst(nrst),
    .opValid(opValid),
    .opKind(opKind),
    .alterDone(alterDone),
    .contextSync(contextSync),
    .syncPending(syncPending)
  );

  // Classification of the reference
  always_comb begin
    wrongDir = req.write && info.readOnly;
    invalidRef = !info.hit || wrongDir;
    privViolation = info.hit && !wrongDir && info.privileged && problemStateBit;
    next_illegal = 1'b0;
    next_priv = 1'b0;
    if (req.valid && invalidRef) begin
      if (!req.number[sra_pkg::SRA_PRIV_BIT]) begin
        next_illegal = 1'b1;
      end else if (!problemStateBit) begin
        next_illegal = 1'b1;
      end else begin
        next_priv = 1'b1;
      end
    end else if (req.valid && privViolation) begin
      next_priv = 1'b1;
    end
    accessOk = req.valid && !invalidRef && !privViolation;
    doWrite = accessOk && req.write;
    doRead = accessOk && !req.write;
    alterDone = doWrite && info.needSyncAfter;
  end

  // Answer, one cycle after the request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ackValid <= 1'b0;
      gprWriteEn <= 1'b0;
      illegalExc <= 1'b0;
      privExc <= 1'b0;
    end else begin
      ackValid <= req.valid;
      gprWriteEn <= doRead;
      illegalExc <= next_illegal;
      privExc <= next_priv;
    end
  end

  // Read data, zero unless a good read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readData <= sra_pkg::SRA_ZERO_WORD;
    end else if (doRead) begin
      readData <= regFile[info.idx];
    end else begin
      readData <= sra_pkg::SRA_ZERO_WORD;
    end
  end

  // Register storage; hardware sets win over software clears
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < sra_pkg::SRA_NUM_REGS; i++) begin
        regFile[i] <= sra_pkg::SRA_ZERO_WORD;
      end
      regFile[sra_pkg::SRA_IDX_CORE_VERSION] <= CORE_VERSION;
    end else begin
      for (int i = 0; i < sra_pkg::SRA_NUM_REGS; i++) begin
        if (sra_pkg::SRA_CLEAR_ON_WRITE[i]) begin
          if (doWrite && info.idx == sra_pkg::SRA_IDX_MC_SYNDROME && i == sra_pkg::SRA_IDX_MC_SYNDROME) begin
            regFile[i] <= (regFile[i] & ~req.data) | mcSyndromeSet;
          end else if (i == sra_pkg::SRA_IDX_MC_SYNDROME) begin
            regFile[i] <= regFile[i] | mcSyndromeSet;
          end else if (doWrite && info.idx == sra_pkg::sra_idx_type'(i)) begin
            regFile[i] <= (regFile[i] & ~req.data) | debugStatusSet;
          end else begin
            regFile[i] <= regFile[i] | debugStatusSet;
          end
        end else if (doWrite && info.idx == sra_pkg::sra_idx_type'(i)) begin
          regFile[i] <= req.data;
        end
      end
    end
  end

  // Live copy of the vector status and control register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vectorStatusControl <= sra_pkg::SRA_ZERO_WORD;
    end else if (doWrite && info.idx == sra_pkg::SRA_IDX_VECTOR_STATUS) begin
      vectorStatusControl <= req.data;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_user_bad_priv;
    req.valid && problemStateBit && !info.hit && req.number[sra_pkg::SRA_PRIV_BIT];
  endsequence

  sequence s_answer_priv;
    ackValid && privExc && !illegalExc && !gprWriteEn;
  endsequence

  sequence s_syndrome_write;
    doWrite && req.number == sra_pkg::SRA_NUM_MC_SYNDROME;
  endsequence

  a_low_bit_illegal: assert property (
    (req.valid && !info.hit && !req.number[sra_pkg::SRA_PRIV_BIT]) |=> (illegalExc && !privExc))
    else $error("unprivileged invalid number did not give illegal");

  a_super_illegal: assert property (
    (req.valid && !info.hit && req.number[sra_pkg::SRA_PRIV_BIT] && !problemStateBit)
      |=> (illegalExc && !privExc))
    else $error("supervisor invalid privileged number did not give illegal");

  a_user_priv: assert property (
    s_user_bad_priv |=> s_answer_priv)
    else $error("user invalid privileged number did not give privilege");

  a_readonly_write: assert property (
    (req.valid && req.write && info.hit && info.readOnly)
      |=> ((illegalExc || privExc) && !gprWriteEn))
    else $error("write to read-only register not refused");

  a_msb_first: assert property (
    (doWrite && info.idx == sra_pkg::SRA_IDX_VECTOR_STATUS)
      |=> vectorStatusControl[0] == $past(req.data[0]))
    else $error("bit 0 not carried as most significant bit");

  a_vector_user: assert property (
    (req.valid && req.number == sra_pkg::SRA_NUM_VECTOR_STATUS && problemStateBit)
      |=> (!privExc && !illegalExc))
    else $error("user access to vector status register refused");

  a_syndrome_user: assert property (
    (req.valid && req.number == sra_pkg::SRA_NUM_MC_SYNDROME && problemStateBit) |=> privExc)
    else $error("user access to machine-check syndrome allowed");

  a_syndrome_clear: assert property (
    s_syndrome_write |=> ((regFile[sra_pkg::SRA_IDX_MC_SYNDROME] & $past(req.data) & ~$past(mcSyndromeSet))
      == sra_pkg::SRA_ZERO_WORD))
    else $error("syndrome bits not cleared by written ones");

  a_syndrome_keep: assert property (
    s_syndrome_write |=> ((regFile[sra_pkg::SRA_IDX_MC_SYNDROME] & ~$past(req.data))
      == (($past(regFile[sra_pkg::SRA_IDX_MC_SYNDROME]) | $past(mcSyndromeSet)) & ~$past(req.data))))
    else $error("syndrome bits without written ones changed");

  a_fault_no_gpr: assert property (
    (ackValid && (illegalExc || privExc)) |-> (!gprWriteEn && readData == sra_pkg::SRA_ZERO_WORD))
    else $error("faulting access wrote a general register");

  a_fault_no_write: assert property (
    (req.valid && req.write && (next_illegal || next_priv))
      |=> vectorStatusControl == $past(vectorStatusControl))
    else $error("faulting write changed a register");

  a_pending_set: assert property (
    alterDone |=> syncPending [*1])
    else $error("write needing trailing sync did not mark pending");

  a_ack_one_cycle: assert property (
    req.valid |=> ackValid ##1 (ackValid == $past(req.valid)))
    else $error("answer not given one cycle after request");

  // Decode, answer and storage checks
  sequence s_super_good;
    req.valid && info.hit && !wrongDir && !problemStateBit;
  endsequence

  sequence s_answer_ok;
    ackValid && !illegalExc && !privExc;
  endsequence

  sequence s_user_priv_reg;
    req.valid && problemStateBit && info.hit && !wrongDir && info.privileged;
  endsequence

  sequence s_bad_write;
    req.valid && req.write && info.hit && !info.clearOnWrite && (next_illegal || next_priv);
  endsequence

  sequence s_plain_write;
    doWrite && !info.clearOnWrite;
  endsequence

  sequence s_status_write;
    doWrite && info.idx == sra_pkg::SRA_IDX_DEBUG_STATUS;
  endsequence

  a_super_ok: assert property (
    s_super_good |=> s_answer_ok)
    else $error("valid supervisor access faulted");

  a_user_reg_priv: assert property (
    s_user_priv_reg |=> s_answer_priv)
    else $error("user access to privileged register not refused");

  a_exc_exclusive: assert property (
    !(illegalExc && privExc))
    else $error("illegal and privilege raised together");

  a_exc_with_ack: assert property (
    (illegalExc || privExc || gprWriteEn) |-> ackValid)
    else $error("answer bit without acknowledge");

  a_priv_user_only: assert property (
    privExc |-> $past(problemStateBit))
    else $error("privilege exception in supervisor state");

  a_illegal_cause: assert property (
    illegalExc |-> (!$past(req.number[sra_pkg::SRA_PRIV_BIT]) || !$past(problemStateBit)))
    else $error("illegal raised for user privileged number");

  a_read_lands: assert property (
    doRead |=> (gprWriteEn && readData == $past(regFile[info.idx])))
    else $error("good read did not return register value");

  a_read_zero: assert property (
    !doRead |=> (!gprWriteEn && readData == sra_pkg::SRA_ZERO_WORD))
    else $error("read data shown without good read");

  a_write_no_gpr: assert property (
    (req.valid && req.write) |=> !gprWriteEn)
    else $error("write enabled a general register");

  a_unmapped_no_gpr: assert property (
    (req.valid && !info.hit) |=> (ackValid && !gprWriteEn && (illegalExc || privExc)))
    else $error("unassigned number not refused");

  a_write_lands: assert property (
    s_plain_write |=> (regFile[$past(info.idx)] == $past(req.data)))
    else $error("good write did not land");

  a_fault_hold: assert property (
    s_bad_write |=> (regFile[$past(info.idx)] == $past(regFile[info.idx])))
    else $error("faulting write changed its register");

  a_version_fixed: assert property (
    regFile[sra_pkg::SRA_IDX_CORE_VERSION] == CORE_VERSION)
    else $error("read-only version register changed");

  a_vector_copy: assert property (
    vectorStatusControl == regFile[sra_pkg::SRA_IDX_VECTOR_STATUS])
    else $error("vector status copy differs from register");

  a_vector_user_write: assert property (
    (doWrite && req.number == sra_pkg::SRA_NUM_VECTOR_STATUS && problemStateBit)
      |=> (vectorStatusControl == $past(req.data)))
    else $error("user write to vector status did not land");

  a_readonly_read: assert property (
    (req.valid && !req.write && info.hit && info.readOnly && !problemStateBit) |=> s_answer_ok)
    else $error("supervisor read of read-only register refused");

  a_wrongdir_illegal: assert property (
    (req.valid && req.write && info.readOnly && !problemStateBit) |=> (illegalExc && !privExc))
    else $error("supervisor write to read-only not illegal");

  a_gpr_with_ok: assert property (
    gprWriteEn |-> (!illegalExc && !privExc))
    else $error("general register written with exception");

  a_syndrome_sets: assert property (
    (mcSyndromeSet != sra_pkg::SRA_ZERO_WORD)
      |=> ((regFile[sra_pkg::SRA_IDX_MC_SYNDROME] & $past(mcSyndromeSet)) == $past(mcSyndromeSet)))
    else $error("syndrome set pulse lost");

  a_status_sets: assert property (
    (debugStatusSet != sra_pkg::SRA_ZERO_WORD)
      |=> ((regFile[sra_pkg::SRA_IDX_DEBUG_STATUS] & $past(debugStatusSet)) == $past(debugStatusSet)))
    else $error("debug status set pulse lost");

  a_status_clear: assert property (
    s_status_write |=> ((regFile[sra_pkg::SRA_IDX_DEBUG_STATUS] & $past(req.data) & ~$past(debugStatusSet))
      == sra_pkg::SRA_ZERO_WORD))
    else $error("debug status bits not cleared by written ones");

  a_status_keep: assert property (
    s_status_write |=> ((regFile[sra_pkg::SRA_IDX_DEBUG_STATUS] & ~$past(req.data))
      == (($past(regFile[sra_pkg::SRA_IDX_DEBUG_STATUS]) | $past(debugStatusSet)) & ~$past(req.data))))
    else $error("debug status bits without written ones changed");

  a_pending_cause: assert property (
    $rose(syncPending) |-> $past(alterDone))
    else $error("pending sync raised without a write");

  a_sync_pulse: assert property (
    contextSync |-> $past(opValid))
    else $error("context sync pulse without an operation");

  a_ack_needs_req: assert property (
    !req.valid |=> !ackValid)
    else $error("acknowledge without request");
endmodule : sra_access_check
`default_nettype wire

// ===== sra_pipe_model.sv
`timescale 1ns/100ps
`default_nettype none
module sra_pipe_model (
  // Clock
  input wire logic clk,
  // Move request
  output sra_pkg::sra_req_type req,
  output logic problemStateBit,
  // Instruction stream
  output logic opValid,
  output sra_pkg::sra_op_type opKind
);
  initial begin
    req = '0;
    problemStateBit = 1'b0;
    opValid = 1'b0;
    opKind = sra_pkg::SRA_OP_NONE;
  end

  // Held to the taking edge, then scrambled so nothing stale is readable
  task automatic move(input logic wr, input sra_pkg::sra_num_type num, input sra_pkg::sra_word_type d,
                      input logic user);
    @(posedge clk);
    #2;
    req = '{valid: 1'b1, write: wr, number: num, data: d};
    problemStateBit = user;
    @(posedge clk);
    #2;
    req = '{valid: 1'b0, write: ~wr, number: ~num, data: ~d};
    problemStateBit = ~user;
  endtask : move

  task automatic issue(input sra_pkg::sra_op_type k);
    @(posedge clk);
    #2;
    opValid = 1'b1;
    opKind = k;
    @(posedge clk);
    #2;
    opValid = 1'b0;
    opKind = sra_pkg::SRA_OP_NONE;
  endtask : issue

  // Leading barriers and syncs, then a supervisor write
  task automatic sync_write(input sra_pkg::sra_num_type num, input sra_pkg::sra_word_type d);
    case (num)
      10'h3F1, 10'h3F2: begin
        issue(sra_pkg::SRA_OP_MSYNC);
        issue(sra_pkg::SRA_OP_ISYNC);
      end
      10'h3BF: issue(sra_pkg::SRA_OP_MSYNC);
      10'h3F4, 10'h3F0: issue(sra_pkg::SRA_OP_SYSCALL);
      default: ;
    endcase
    move(1'b1, num, d, 1'b0);
  endtask : sync_write

  // Trailing sync after the write
  task automatic trail(input sra_pkg::sra_num_type num);
    issue(num == 10'h3F0 ? sra_pkg::SRA_OP_ISYNC : sra_pkg::SRA_OP_RFI);
  endtask : trail

  // Leading barrier or sync before a read
  task automatic lead_read(input sra_pkg::sra_num_type num);
    case (num)
      10'h3F1, 10'h232: issue(sra_pkg::SRA_OP_MSYNC);
      10'h3F4: issue(sra_pkg::SRA_OP_SYSCALL);
      default: ;
    endcase
  endtask : lead_read
endmodule : sra_pipe_model
`default_nettype wire

// ===== tb_sra_access_check.sv
`timescale 1ns/100ps
`default_nettype none
module tb_sra_access_check;
  // Arbitrary value, not a real part code
  localparam sra_pkg::sra_word_type VER = 32'h5A5A_0003;
  localparam sra_pkg::sra_word_type Z = 32'h0000_0000;
  localparam logic [1:0] OK = 2'b00;
  localparam logic [1:0] ILL = 2'b10;
  localparam logic [1:0] PRV = 2'b01;
  logic clk;
  logic nrst;
  sra_pkg::sra_req_type req;
  logic problemStateBit;
  logic opValid;
  sra_pkg::sra_op_type opKind;
  sra_pkg::sra_word_type mcSyndromeSet;
  sra_pkg::sra_word_type debugStatusSet;
  logic ackValid;
  logic gprWriteEn;
  sra_pkg::sra_word_type readData;
  logic illegalExc;
  logic privExc;
  logic contextSync;
  logic syncPending;
  sra_pkg::sra_word_type vectorStatusControl;
  int bad_count = 0;
  int cmp_count = 0;
  sra_pkg::sra_num_type sNum [10] = '{10'h3F1, 10'h3F2, 10'h3F3, 10'h3F4, 10'h3BF, 10'h3F5, 10'h134,
                                      10'h232, 10'h200, 10'h3F0};

  sra_access_check #(.CORE_VERSION(VER)) sra_access_check_inst (
    .clk(clk), .nrst(nrst), .req(req), .problemStateBit(problemStateBit), .opValid(opValid),
    .opKind(opKind), .mcSyndromeSet(mcSyndromeSet), .debugStatusSet(debugStatusSet),
    .ackValid(ackValid), .gprWriteEn(gprWriteEn), .readData(readData), .illegalExc(illegalExc),
    .privExc(privExc), .contextSync(contextSync), .syncPending(syncPending),
    .vectorStatusControl(vectorStatusControl)
  );

  sra_pipe_model sra_pipe_model_inst (
    .clk(clk), .req(req), .problemStateBit(problemStateBit), .opValid(opValid), .opKind(opKind)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One move and its one-cycle answer
  task automatic mv(input logic wr, input sra_pkg::sra_num_type num, input sra_pkg::sra_word_type d,
                    input logic user, input logic [1:0] exc, input sra_pkg::sra_word_type exp);
    sra_pipe_model_inst.move(wr, num, d, user);
    check({ackValid, gprWriteEn, illegalExc, privExc, readData}, {1'b1, ~wr & ~|exc, exc, exp});
  endtask : mv

  initial begin
    #(2000 * 25);
    bad_count++;
    conclude();
  end

  initial begin
    nrst = 1'b0;
    mcSyndromeSet = Z;
    debugStatusSet = Z;
    repeat (6) @(posedge clk);
    #2;
    nrst = 1'b1;
    check(36'(vectorStatusControl), 36'(Z));
    mv(1'b0, 10'h11F, Z, 1'b0, OK, VER);
    mv(1'b1, 10'h11F, 32'h0000_0001, 1'b0, ILL, Z);
    mv(1'b1, 10'h11F, 32'h0000_0001, 1'b1, PRV, Z);
    mv(1'b1, 10'h203, 32'h0000_0001, 1'b1, ILL, Z);
    mv(1'b0, 10'h3FF, Z, 1'b0, ILL, Z);
    mv(1'b0, 10'h3FF, Z, 1'b1, PRV, Z);
    mv(1'b0, 10'h001, Z, 1'b1, ILL, Z);
    mv(1'b0, 10'h11F, Z, 1'b0, OK, VER);
    mv(1'b1, 10'h008, 32'h8000_0001, 1'b1, OK, Z);
    mv(1'b0, 10'h008, Z, 1'b1, OK, 32'h8000_0001);
    check(36'(readData[0]), 36'h1);
    mv(1'b1, 10'h200, 32'h0000_00C3, 1'b1, OK, Z);
    check(36'({vectorStatusControl, syncPending}), {3'h0, 32'h0000_00C3, 1'b1});
    for (int i = 0; i < 10; i++) begin
      sra_pipe_model_inst.sync_write(sNum[i], {sNum[i], sNum[i], sNum[i], 2'h1});
      check({32'h0, ackValid, illegalExc, privExc, syncPending}, {32'h0, 3'b100, i < 9});
      sra_pipe_model_inst.trail(sNum[i]);
      check({34'h0, contextSync, syncPending}, 36'h2);
      sra_pipe_model_inst.lead_read(sNum[i]);
      mv(1'b0, sNum[i], Z, 1'b0, OK, {sNum[i], sNum[i], sNum[i], 2'h1});
    end
    mv(1'b1, 10'h3F0, 32'hFFFF_FFFF, 1'b1, PRV, Z);
    mv(1'b0, 10'h3F0, Z, 1'b1, PRV, Z);
    mv(1'b0, 10'h3F0, Z, 1'b0, OK, {10'h3F0, 10'h3F0, 10'h3F0, 2'h1});
    for (int k = 0; k < 7; k++) begin
      sra_pipe_model_inst.issue(sra_pkg::sra_op_type'(k[2:0]));
      check({35'h0, contextSync}, {35'h0, k >= 1 && k <= 5});
    end
    @(posedge clk);
    #2;
    mcSyndromeSet = 32'hF0F0_0000;
    debugStatusSet = 32'h0000_0F0F;
    @(posedge clk);
    #2;
    mcSyndromeSet = Z;
    debugStatusSet = Z;
    mv(1'b0, 10'h23C, Z, 1'b1, PRV, Z);
    mv(1'b0, 10'h23C, Z, 1'b0, OK, 32'hF0F0_0000);
    mv(1'b1, 10'h23C, 32'h3000_0001, 1'b0, OK, Z);
    mv(1'b0, 10'h23C, Z, 1'b0, OK, 32'hC0F0_0000);
    fork
      sra_pipe_model_inst.move(1'b1, 10'h23C, 32'hC000_0000, 1'b0);
      begin
        @(posedge clk);
        #2;
        mcSyndromeSet = 32'h8000_0000;
        @(posedge clk);
        #2;
        mcSyndromeSet = Z;
      end
    join
    mv(1'b0, 10'h23C, Z, 1'b0, OK, 32'h80F0_0000);
    mv(1'b1, 10'h130, 32'h0000_0F00, 1'b0, OK, Z);
    mv(1'b0, 10'h130, Z, 1'b0, OK, 32'h0000_000F);
    conclude();
  end
endmodule : tb_sra_access_check
`default_nettype wire
